// File: include/svm_pkg.sv
// Shared constants, register map and carrier types of the supply voltage monitor.
package svm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned RES_W = 8;
    localparam int unsigned CHAN_W = 5;
    localparam int unsigned STAT_W = 2;

    // Reference settling least time, rounded up to whole cycles.
    localparam int unsigned REF_STAB_NS = 5000;
    localparam int unsigned REF_STAB_CYCLES = (REF_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REF_CNT_W = $clog2(REF_STAB_CYCLES + 1);

    // Trigger interval, rounded down to whole cycles.
    localparam int unsigned TRIG_PERIOD_NS = 100000;
    localparam int unsigned TRIG_CYCLES = TRIG_PERIOD_NS / CLK_PERIOD_NS;

    // Blink period; the output toggles every half period.
    localparam int unsigned BLINK_PERIOD_MS = 500;
    localparam int unsigned BLINK_HALF_CYCLES = BLINK_PERIOD_MS * 1000 / 2 * 1000 / CLK_PERIOD_NS;

    // Conversion length in cycles from trigger to result.
    localparam int unsigned CONV_CYCLES = 22;

    localparam logic [RES_W-1:0] LV_THRESHOLD = 8'h5f;
    localparam logic [CHAN_W-1:0] CH_ANALOG_INPUT_ZERO = 5'h00;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_CHAN = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_MASK = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STATE = 4'h5;

    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned CTRL_CMP_BIT = 1;
    localparam int unsigned CTRL_REFL_BIT = 2;
    localparam int unsigned CTRL_REFH_BIT = 3;
    localparam int unsigned CTRL_BLINK_STOP_BIT = 4;

    localparam int unsigned ST_LOW_VOLT_BIT = 0;
    localparam int unsigned ST_TRIG_LOST_BIT = 1;

    localparam logic [STAT_W-1:0] STATUS_RESET = 2'h0;
    localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h00;

    typedef struct packed {
        logic pos_ref_select_high;
        logic pos_ref_select_low;
        logic comparator_enable;
        logic conversion_run;
    } svm_ctrl_s;

    localparam svm_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } svm_req_s;
endpackage

// File: hdl/svm_interval_timer.sv
// Interval timer that issues a one-cycle trigger pulse every period while running.
`timescale 1ns/10ps
`default_nettype none
module svm_interval_timer #(
    parameter int unsigned PERIOD = svm_pkg::TRIG_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    output logic tick_o
);
    import svm_pkg::*;

    localparam int unsigned CNT_W = $clog2(PERIOD);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_tick;

    // Stopping restarts the count so the first trigger comes a full period after start.
    always_comb begin
        next_cnt = '0;
        next_tick = 1'b0;
        if (run_i) begin
            if (cnt == LAST) begin
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule
`default_nettype wire

// File: hdl/svm_blink_timer.sv
// Square-wave timer output that toggles every half period while enabled.
`timescale 1ns/10ps
`default_nettype none
module svm_blink_timer #(
    parameter int unsigned HALF = svm_pkg::BLINK_HALF_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic run_i,
    output logic out_o
);
    import svm_pkg::*;

    localparam int unsigned CNT_W = $clog2(HALF);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF - 1);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_out;

    // When disabled the output returns low at once, so the lamp never stays lit.
    always_comb begin
        next_cnt = '0;
        next_out = 1'b0;
        if (run_i) begin
            next_out = out_o;
            if (cnt == LAST) begin
                next_out = ~out_o;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= '0;
            out_o <= 1'b0;
        end else if (ce_i) begin
            cnt <= next_cnt;
            out_o <= next_out;
        end
    end
endmodule
`default_nettype wire

// File: hdl/svm_ctrl.sv
// Supply voltage monitor converter control with register port, interrupt and LED timer.
//
// How it works
// - Triggered conversions start with no extra wait.
// - Each conversion yields an eight-bit result.
// - Interval timer pulse every 100 us triggers.
// - Result at or below 0x5F raises interrupt.
// - Low voltage starts LED blinking, half-second period.
// - One conversion per trigger, then wait again.
// - Only channel 0 (analog input zero) is converted; any other channel setting blocks conversions.
`timescale 1ns/10ps
`default_nettype none
module svm_ctrl #(
    parameter int unsigned TRIG_PERIOD = svm_pkg::TRIG_CYCLES,
    parameter int unsigned BLINK_HALF = svm_pkg::BLINK_HALF_CYCLES,
    parameter int unsigned CONV_LEN = svm_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [svm_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [svm_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [svm_pkg::RES_W-1:0] ain_code_i,
    output logic [svm_pkg::DATA_W-1:0] reg_rdata_o,
    output logic irq_o,
    output logic conv_start_o,
    output logic led_timer_output_o
);
    import svm_pkg::*;

    localparam int unsigned CONV_W = $clog2(CONV_LEN);
    localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_LEN - 1);

    typedef enum logic [0:0] {
        CS_IDLE,
        CS_BUSY
    } svm_conv_e;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction

    function automatic logic ref_internal(input svm_ctrl_s c);
        ref_internal = c.pos_ref_select_high & ~c.pos_ref_select_low;
    endfunction

    svm_req_s req;
    svm_ctrl_s ctrl;
    svm_ctrl_s next_ctrl;
    logic [CHAN_W-1:0] chan;
    logic [CHAN_W-1:0] next_chan;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] next_status;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] next_mask;
    logic [REF_CNT_W-1:0] ref_cnt;
    logic [REF_CNT_W-1:0] next_ref_cnt;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] next_result;
    logic [CONV_W-1:0] conv_cnt;
    logic [CONV_W-1:0] next_conv_cnt;
    svm_conv_e conv_state;
    svm_conv_e next_conv_state;
    logic blink_on;
    logic next_blink_on;
    logic next_irq;
    logic next_conv_start;
    logic [DATA_W-1:0] next_rdata;
    logic [RES_W-1:0] ain_meta;
    logic [RES_W-1:0] ain_sync;
    logic trig_tick;
    logic ref_stable;
    logic wr_ctrl;
    logic ref_write;
    logic accept;
    logic conv_end;
    logic low_event;
    logic lost_event;
    logic [STAT_W-1:0] set_bits;
    logic [STAT_W-1:0] clr_bits;

    assign req = '{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i};
    assign wr_ctrl = req.wr && reg_hit(req.addr, OFF_CTRL);
    assign ref_stable = (ref_cnt == REF_CNT_W'(REF_STAB_CYCLES));

    // The front end holds its code steady around the sampling point, so a plain
    // two-stage synchroniser per bit is adequate here.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ain_meta <= '0;
            ain_sync <= '0;
        end else if (ce_i) begin
            ain_meta <= ain_code_i;
            ain_sync <= ain_meta;
        end
    end

    svm_interval_timer #(
        .PERIOD(TRIG_PERIOD)
    ) u_trig (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .run_i(ctrl.conversion_run),
        .tick_o(trig_tick)
    );

    // Control register and reference settling counter.
    always_comb begin
        next_ctrl = ctrl;
        next_chan = chan;
        next_ref_cnt = ref_cnt;
        ref_write = 1'b0;
        if (wr_ctrl) begin
            next_ctrl.conversion_run = req.wdata[CTRL_RUN_BIT];
            // A reference change under a running converter would corrupt results.
            if (!ctrl.conversion_run && !ctrl.comparator_enable) begin
                next_ctrl.pos_ref_select_high = req.wdata[CTRL_REFH_BIT];
                next_ctrl.pos_ref_select_low = req.wdata[CTRL_REFL_BIT];
                ref_write = (req.wdata[CTRL_REFH_BIT] != ctrl.pos_ref_select_high) ||
                            (req.wdata[CTRL_REFL_BIT] != ctrl.pos_ref_select_low);
            end
            next_ctrl.comparator_enable = req.wdata[CTRL_CMP_BIT] &&
                (ctrl.comparator_enable || (ref_stable && ref_internal(ctrl)));
        end
        if (req.wr && reg_hit(req.addr, OFF_CHAN)) begin
            next_chan = req.wdata[CHAN_W-1:0];
        end
        if (ref_write || !ref_internal(ctrl)) begin
            next_ref_cnt = '0;
        end else if (!ref_stable) begin
            next_ref_cnt = ref_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= CTRL_RESET;
            chan <= CHAN_RESET;
            ref_cnt <= '0;
        end else if (ce_i) begin
            ctrl <= next_ctrl;
            chan <= next_chan;
            ref_cnt <= next_ref_cnt;
        end
    end

    // Conversion sequencer: one conversion per accepted trigger.
    always_comb begin
        next_conv_state = conv_state;
        next_conv_cnt = conv_cnt;
        next_result = result;
        accept = 1'b0;
        conv_end = 1'b0;
        lost_event = 1'b0;
        unique case (conv_state)
            CS_IDLE: begin
                // The reference already settled before enable, so no per-trigger wait.
                if (trig_tick && ctrl.conversion_run && ctrl.comparator_enable &&
                    chan == CH_ANALOG_INPUT_ZERO) begin
                    accept = 1'b1;
                    next_conv_cnt = '0;
                    next_conv_state = CS_BUSY;
                end
            end
            CS_BUSY: begin
                lost_event = trig_tick;
                if (conv_cnt == CONV_LAST) begin
                    conv_end = 1'b1;
                    next_result = ain_sync;
                    next_conv_state = CS_IDLE;
                end else begin
                    next_conv_cnt = conv_cnt + 1'b1;
                end
                if (!ctrl.comparator_enable) begin
                    next_conv_state = CS_IDLE;
                end
            end
        endcase
        low_event = conv_end && (ain_sync <= LV_THRESHOLD);
        next_conv_start = accept;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conv_state <= CS_IDLE;
            conv_cnt <= '0;
            result <= '0;
            conv_start_o <= 1'b0;
        end else if (ce_i) begin
            conv_state <= next_conv_state;
            conv_cnt <= next_conv_cnt;
            result <= next_result;
            conv_start_o <= next_conv_start;
        end
    end

    // Status, mask, interrupt and LED enable. A new event wins over a clear.
    always_comb begin
        set_bits = '0;
        set_bits[ST_LOW_VOLT_BIT] = low_event;
        set_bits[ST_TRIG_LOST_BIT] = lost_event;
        clr_bits = '0;
        if (req.wr && reg_hit(req.addr, OFF_STATUS)) begin
            clr_bits = req.wdata[STAT_W-1:0];
        end
        next_status = (status & ~clr_bits) | set_bits;
        next_mask = mask;
        if (req.wr && reg_hit(req.addr, OFF_MASK)) begin
            next_mask = req.wdata[STAT_W-1:0];
        end
        next_irq = |(next_status & next_mask);
        next_blink_on = blink_on;
        if (wr_ctrl && req.wdata[CTRL_BLINK_STOP_BIT]) begin
            next_blink_on = 1'b0;
        end
        if (low_event) begin
            next_blink_on = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status <= STATUS_RESET;
            mask <= MASK_RESET;
            irq_o <= 1'b0;
            blink_on <= 1'b0;
        end else if (ce_i) begin
            status <= next_status;
            mask <= next_mask;
            irq_o <= next_irq;
            blink_on <= next_blink_on;
        end
    end

    svm_blink_timer #(
        .HALF(BLINK_HALF)
    ) u_blink (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .run_i(blink_on),
        .out_o(led_timer_output_o)
    );

    // Read port: data stand only in the cycle after the strobe.
    always_comb begin
        next_rdata = '0;
        if (req.rd) begin
            unique case (1'b1)
                reg_hit(req.addr, OFF_CTRL): begin
                    next_rdata = DATA_W'(ctrl);
                end
                reg_hit(req.addr, OFF_CHAN): begin
                    next_rdata = DATA_W'(chan);
                end
                reg_hit(req.addr, OFF_STATUS): begin
                    next_rdata = DATA_W'(status);
                end
                reg_hit(req.addr, OFF_MASK): begin
                    next_rdata = DATA_W'(mask);
                end
                reg_hit(req.addr, OFF_RESULT): begin
                    next_rdata = DATA_W'(result);
                end
                reg_hit(req.addr, OFF_STATE): begin
                    next_rdata = DATA_W'({conv_state == CS_BUSY, ref_stable, blink_on});
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// File: tb/svm_ctrl_props.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module svm_ctrl_props #(
    parameter int unsigned TRIG_PERIOD = svm_pkg::TRIG_CYCLES,
    parameter int unsigned BLINK_HALF = svm_pkg::BLINK_HALF_CYCLES,
    parameter int unsigned CONV_LEN = svm_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [svm_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [svm_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [svm_pkg::RES_W-1:0] ain_code_i,
    input wire logic [svm_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic conv_start_o,
    input wire logic led_timer_output_o
);
    import svm_pkg::*;
    int unsigned gap;
    int unsigned since_start;
    logic have_prev;
    logic chan_ok;
    // The start counter saturates so a long idle stretch cannot wrap into a match.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap <= 0;
            since_start <= 32'h0000ffff;
            have_prev <= 1'b0;
            chan_ok <= 1'b1;
        end else begin
            gap <= conv_start_o ? 0 : gap + 1;
            if (conv_start_o) begin
                since_start <= 0;
                have_prev <= 1'b1;
            end else if (since_start < 32'h0000ffff) begin
                since_start <= since_start + 1;
            end
            if (ce_i && reg_wr_i && reg_addr_i == OFF_CHAN) begin
                chan_ok <= (reg_wdata_i[CHAN_W-1:0] == '0);
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_quiet3;
        !conv_start_o [*3];
    endsequence
    sequence s_led_hold;
        $stable(led_timer_output_o) [*3];
    endsequence
    AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
        else $error("conversion start longer than one cycle");
    AST_START_GAP: assert property (conv_start_o |=> s_quiet3)
        else $error("conversion start while busy");
    AST_START_PERIOD: assert property (conv_start_o && have_prev |-> (gap + 1) % TRIG_PERIOD == 0)
        else $error("conversion start off the trigger grid");
    AST_START_CHAN: assert property (conv_start_o |-> $past(chan_ok))
        else $error("conversion started on a nonzero channel");
    AST_RESET_QUIET: assert property ($fell(sys_rst_i) |-> !irq_o && !led_timer_output_o
        && !conv_start_o && reg_rdata_o == 8'h00)
        else $error("outputs active at reset release");
    AST_LED_HALF: assert property ($changed(led_timer_output_o) && BLINK_HALF >= 4 |=> s_led_hold)
        else $error("led output toggled early");
    AST_MASK_OFF: assert property (ce_i && reg_wr_i && reg_addr_i == OFF_MASK
        && reg_wdata_i[STAT_W-1:0] == '0 |=> !irq_o)
        else $error("interrupt high with mask cleared");
    AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(reg_wr_i)
        || since_start < CONV_LEN + 3)
        else $error("interrupt rose without a conversion end");
    AST_RD_IDLE: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside the read cycle");
endmodule
bind svm_ctrl svm_ctrl_props #(.TRIG_PERIOD(TRIG_PERIOD), .BLINK_HALF(BLINK_HALF),
    .CONV_LEN(CONV_LEN)) svm_ctrl_props_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .ain_code_i(ain_code_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .conv_start_o(conv_start_o), .led_timer_output_o(led_timer_output_o));
`default_nettype wire

// File: tb/svm_supply_model.sv
// Behavioural divided-supply source that feeds the converter input code.
`timescale 1ns/10ps
`default_nettype none
module svm_supply_model (
    input wire logic clk_i,
    input wire logic [svm_pkg::RES_W-1:0] target_i,
    output logic [svm_pkg::RES_W-1:0] ain_code_o
);
    import svm_pkg::*;
    logic [RES_W-1:0] code = 8'h80;
    // The supply drifts slowly, so the code moves one step per clock toward the target.
    always @(posedge clk_i) begin
        if (code < target_i) begin
            code <= code + 8'h01;
        end else if (code > target_i) begin
            code <= code - 8'h01;
        end
    end
    assign ain_code_o = code;
endmodule
`default_nettype wire

// File: tb/svm_ctrl_tb.sv
// Self-checking bench for the supply monitor converter control.
`timescale 1ns/10ps
`default_nettype none
module svm_ctrl_tb;
    import svm_pkg::*;
    localparam int TP = 20;
    localparam int BH = 4;
    localparam int CL = 4;
    logic clk_i;
    logic sys_rst_i;
    logic ce_i;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [RES_W-1:0] supply_target;
    logic [RES_W-1:0] ain_code;
    logic [DATA_W-1:0] reg_rdata;
    logic irq;
    logic conv_start;
    logic led;
    int fail_count;
    int compares;
    int n;
    svm_supply_model svm_supply_model_inst (.clk_i(clk_i), .target_i(supply_target),
        .ain_code_o(ain_code));
    // Short counts keep the run brief; every timing expectation below except the reference settling wait derives from them.
    svm_ctrl #(.TRIG_PERIOD(TP), .BLINK_HALF(BH), .CONV_LEN(CL)) svm_ctrl_inst (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .ain_code_i(ain_code), .reg_rdata_o(reg_rdata),
        .irq_o(irq), .conv_start_o(conv_start), .led_timer_output_o(led));
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_cnt(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_i);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_i);
        reg_rd <= 1'b0;
        #1;
        chk8(what, exp, reg_rdata);
    endtask
    // Waits for a level on the start pulse (sel 0) or the led output, with a bound.
    task automatic wait_for(input int sel, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            #1;
            cnt++;
            if (cnt > lim) begin
                fail_count++;
                $display("Error wait on %0d expected within %0d seen %0d", sel, lim, cnt);
                give_verdict();
            end
        end while (((sel == 0) ? conv_start : led) !== lvl);
    endtask
    // Counts start pulses seen over a fixed number of cycles.
    task automatic count_starts(input int cycles, output int cnt);
        cnt = 0;
        repeat (cycles) begin
            @(posedge clk_i);
            #1;
            if (conv_start === 1'b1) begin
                cnt++;
            end
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        fail_count = 0;
        compares = 0;
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        supply_target = 8'h60;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd_chk("reset value", a[3:0], 8'h00);
        end
        $display("Test reset values done");
        wr(OFF_CTRL, 8'h08);
        rd_chk("ctrl reference", OFF_CTRL, 8'h08);
        wr(OFF_CTRL, 8'h0a);
        rd_chk("ctrl early enable", OFF_CTRL, 8'h08);
        repeat (REF_STAB_CYCLES + 5) @(posedge clk_i);
        wr(OFF_CTRL, 8'h0a);
        rd_chk("ctrl enable", OFF_CTRL, 8'h0a);
        wr(OFF_CTRL, 8'h02);
        rd_chk("ctrl reference locked", OFF_CTRL, 8'h0a);
        wr(OFF_CHAN, 8'h00);
        wr(OFF_MASK, 8'h01);
        wr(OFF_CTRL, 8'h0b);
        wait_for(0, 1'b1, TP + 4, n);
        chk_cnt("first start in time", 1, (n <= TP + 2) ? 1 : 0);
        wait_for(0, 1'b1, TP + 4, n);
        chk_cnt("trigger period", TP, n);
        repeat (CL + 3) @(posedge clk_i);
        rd_chk("result above threshold", OFF_RESULT, 8'h60);
        rd_chk("status above threshold", OFF_STATUS, 8'h00);
        chk8("irq above threshold", 8'h00, {7'h00, irq});
        $display("Test setup and trigger done");
        supply_target <= 8'h5f;
        wait_for(0, 1'b1, TP + 4, n);
        wait_for(0, 1'b1, TP + 4, n);
        repeat (CL + 3) @(posedge clk_i);
        rd_chk("result at threshold", OFF_RESULT, 8'h5f);
        rd_chk("status at threshold", OFF_STATUS, 8'h01);
        chk8("irq at threshold", 8'h01, {7'h00, irq});
        wait_for(1, 1'b1, 2 * BH + 2, n);
        wait_for(1, 1'b0, BH + 2, n);
        chk_cnt("blink half period", BH, n);
        $display("Test low supply done");
        supply_target <= 8'h61;
        // The stop lands while the lamp is low, so no short half period appears.
        wr(OFF_CTRL, 8'h1b);
        rd_chk("ctrl after blink stop", OFF_CTRL, 8'h0b);
        wait_for(0, 1'b1, TP + 4, n);
        wait_for(0, 1'b1, TP + 4, n);
        repeat (CL + 3) @(posedge clk_i);
        wr(OFF_MASK, 8'h00);
        @(posedge clk_i);
        #1;
        chk8("irq masked", 8'h00, {7'h00, irq});
        wr(OFF_STATUS, 8'h01);
        rd_chk("status cleared", OFF_STATUS, 8'h00);
        wr(OFF_MASK, 8'h01);
        @(posedge clk_i);
        #1;
        chk8("irq after clear", 8'h00, {7'h00, irq});
        chk8("led after stop", 8'h00, {7'h00, led});
        $display("Test interrupt clear done");
        wait_for(0, 1'b1, TP + 4, n);
        wr(OFF_CHAN, 8'h01);
        count_starts(2 * TP, n);
        chk_cnt("starts on another channel", 0, n);
        wr(OFF_CHAN, 8'h00);
        wait_for(0, 1'b1, TP + 4, n);
        $display("Test channel select done");
        // Freezing for whole trigger periods keeps the start grid intact.
        @(posedge clk_i);
        ce_i <= 1'b0;
        count_starts(2 * TP, n);
        ce_i <= 1'b1;
        chk_cnt("starts while frozen", 0, n);
        wait_for(0, 1'b1, TP + 4, n);
        chk_cnt("start after freeze", TP - 1, n);
        $display("Test clock enable done");
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk8("outputs in reset", 8'h00, {5'h00, irq, conv_start, led});
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd_chk("ctrl after reset", OFF_CTRL, 8'h00);
        $display("Test mid-run reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
